// ==== cpu_ctl_pkg.sv ====
// Package with register map, field positions and encodings for the CPU control block.
`default_nettype none
package cpu_ctl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INTACK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_VECTOR = 8'h10;
    localparam int CTRL_IF_BIT = 0;
    localparam int CTRL_TYPE_LSB = 8;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_START_BIT = 3;
    localparam int CMD_INSTR_END_BIT = 4;
    localparam int CMD_WAIT_BIT = 5;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_MAX_BIT = 4;
    localparam int ST_NMI_PEND_BIT = 5;
    localparam int ST_WAITING_BIT = 6;
    localparam int ST_CORE_RST_BIT = 7;
    localparam int ACK_IRQ_BIT = 0;
    localparam int ACK_NMI_BIT = 1;
    localparam int ACK_TYPE_LSB = 8;
    localparam int TYPE_W = 8;
    localparam logic [2:0] STATUS_PASSIVE = 3'h7;
    localparam logic [TYPE_W-1:0] NMI_TYPE = 8'h02;
    localparam logic [TYPE_W-1:0] IRQ_TYPE_RESET = 8'h08;
    localparam int VEC_SHIFT = 2;
    localparam int RESET_MIN_CYCLES = 4;
    localparam int WAIT_TEST_LAT = 4;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_LEAD = 3'b001,
        BUS_STATE_ONE = 3'b010,
        BUS_STATE_TWO = 3'b011,
        BUS_STATE_THREE = 3'b100,
        BUS_WAIT_STATE = 3'b101,
        BUS_TAIL = 3'b110
    } bus_state_e;
endpackage
`default_nettype wire

// ==== pin_sync3.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    output logic q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // The first stage is only read by the second, so a metastable value never reaches logic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= RESET_VAL;
        else if (s2_q == s3_q)
            q <= s3_q;
    end
endmodule
`default_nettype wire

// ==== cpu_ctl.sv ====
// CPU control inputs, interrupt sampling, wait/test handling and maximum mode bus status.
// Summary of operation
// - Bus cycle stays open until acknowledge seen.
// - Maskable request sampled at instruction end.
// - Maskable request ignored while enable flag clear.
// - Maskable request passes internal synchroniser.
// - Handler address comes from vector table.
// - Wait instruction idles until test low.
// - Test input synchronised on every rising clock edge.
// - Non-maskable input edge triggered, type two.
// - Rising edge serviced at instruction end, unmaskable.
// - Non-maskable input synchronised before edge detect.
// - Reset abandons current operation at once.
// - Reset synchronised; restart from start state.
// - Mode input low selects maximum mode status.
// - Status valid in four, one, two; passive after. Code holds it active until ready_in is seen in state two, three or wait.
// - Status leaving passive starts, returning ends cycle.
// - Enable flag shown on status line each cycle.
`timescale 1ns/10ps
`default_nettype none
module cpu_ctl
    import cpu_ctl_pkg::*;
#(
    parameter logic [31:0] VECTOR_BASE = 32'h0000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ready_in,
    input wire logic maskable_irq_in,
    input wire logic nmi_in,
    input wire logic test_n_in,
    input wire logic reset_in,
    input wire logic mode_select_in,
    output logic [2:0] bus_cycle_status_out,
    output logic irq_enable_status_line,
    output logic irq_ack_out
);
    logic irq_s;
    logic nmi_s;
    logic test_s;
    logic rst_s;
    logic mode_s;
    logic nmi_prev_q;
    logic nmi_pend_q;
    logic if_flag_q;
    logic [TYPE_W-1:0] irq_type_q;
    logic irq_taken_q;
    logic nmi_taken_q;
    logic [TYPE_W-1:0] taken_type_q;
    logic [31:0] vector_q;
    logic waiting_q;
    logic max_mode_q;
    logic mode_caught_q;
    logic [2:0] code_q;
    logic [2:0] status_q;
    bus_state_e state_q;
    bus_state_e state_d;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic cmd_wr;
    logic start_req;
    logic instr_end;
    logic wait_req;
    logic nmi_edge;
    logic take_nmi;
    logic take_irq;
    logic [31:0] rdata_d;

    pin_sync3 #(.RESET_VAL(1'b0)) u_irq_sync (
        .pclk(pclk), .presetn(presetn), .d(maskable_irq_in), .q(irq_s)
    );
    pin_sync3 #(.RESET_VAL(1'b0)) u_nmi_sync (
        .pclk(pclk), .presetn(presetn), .d(nmi_in), .q(nmi_s)
    );
    pin_sync3 #(.RESET_VAL(1'b1)) u_test_sync (
        .pclk(pclk), .presetn(presetn), .d(test_n_in), .q(test_s)
    );
    pin_sync3 #(.RESET_VAL(1'b1)) u_rst_sync (
        .pclk(pclk), .presetn(presetn), .d(reset_in), .q(rst_s)
    );
    pin_sync3 #(.RESET_VAL(1'b1)) u_mode_sync (
        .pclk(pclk), .presetn(presetn), .d(mode_select_in), .q(mode_s)
    );

    // Every register answers in its access cycle, so the bus never sees a wait state.
    assign pready = 1'b1;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_CMD) || (paddr == OFS_STATUS) ||
                     (paddr == OFS_INTACK) || (paddr == OFS_VECTOR);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign cmd_wr = wr_en && (paddr == OFS_CMD) && !rst_s;
    assign start_req = cmd_wr && pwdata[CMD_START_BIT];
    assign instr_end = cmd_wr && pwdata[CMD_INSTR_END_BIT];
    assign wait_req = cmd_wr && pwdata[CMD_WAIT_BIT];
    assign nmi_edge = nmi_s && !nmi_prev_q;
    assign take_nmi = instr_end && (nmi_pend_q || nmi_edge);
    assign take_irq = instr_end && !take_nmi && irq_s && if_flag_q;
    assign irq_ack_out = irq_taken_q || nmi_taken_q;

    // The mode strap is caught once after reset, so a moving pin cannot flip the bus mid-cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_caught_q <= 1'b0;
            max_mode_q <= 1'b0;
        end
        else if (rst_s)
            mode_caught_q <= 1'b0;
        else if (!mode_caught_q)
        begin
            mode_caught_q <= 1'b1;
            max_mode_q <= !mode_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            if_flag_q <= 1'b0;
            irq_type_q <= IRQ_TYPE_RESET;
        end
        else if (rst_s)
            if_flag_q <= 1'b0;
        else if (wr_en && paddr == OFS_CTRL)
        begin
            if_flag_q <= pwdata[CTRL_IF_BIT];
            irq_type_q <= pwdata[CTRL_TYPE_LSB +: TYPE_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_enable_status_line <= 1'b0;
        else
            irq_enable_status_line <= if_flag_q;
    end

    // The edge detector resets low like the idle pin, so leaving reset cannot fake an edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end
        else
        begin
            nmi_prev_q <= nmi_s;
            if (rst_s || take_nmi)
                nmi_pend_q <= 1'b0;
            else if (nmi_edge)
                nmi_pend_q <= 1'b1;
        end
    end

    // A fresh interrupt taken in the cycle that software clears the flags keeps its flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_taken_q <= 1'b0;
            nmi_taken_q <= 1'b0;
            taken_type_q <= '0;
            vector_q <= '0;
        end
        else if (rst_s)
        begin
            irq_taken_q <= 1'b0;
            nmi_taken_q <= 1'b0;
        end
        else
        begin
            if (take_nmi || take_irq)
            begin
                taken_type_q <= take_nmi ? NMI_TYPE : irq_type_q;
                vector_q <= VECTOR_BASE + (32'(take_nmi ? NMI_TYPE : irq_type_q) << VEC_SHIFT);
            end
            if (take_irq)
                irq_taken_q <= 1'b1;
            else if (wr_en && paddr == OFS_INTACK && pwdata[ACK_IRQ_BIT])
                irq_taken_q <= 1'b0;
            if (take_nmi)
                nmi_taken_q <= 1'b1;
            else if (wr_en && paddr == OFS_INTACK && pwdata[ACK_NMI_BIT])
                nmi_taken_q <= 1'b0;
        end
    end

    // Test is seen through the synchroniser, so a wait ends some edges after the pin falls.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            waiting_q <= 1'b0;
        else if (rst_s)
            waiting_q <= 1'b0;
        else if (wait_req)
            waiting_q <= test_s;
        else if (waiting_q && !test_s)
            waiting_q <= 1'b0;
    end

    // Acknowledge is used as it arrives, which saves latency but needs it synchronous already.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BUS_IDLE: if (start_req) state_d = BUS_LEAD;
            BUS_LEAD: state_d = BUS_STATE_ONE;
            BUS_STATE_ONE: state_d = BUS_STATE_TWO;
            BUS_STATE_TWO: state_d = BUS_STATE_THREE;
            BUS_STATE_THREE, BUS_WAIT_STATE: state_d = ready_in ? BUS_TAIL : BUS_WAIT_STATE;
            BUS_TAIL: state_d = start_req ? BUS_LEAD : BUS_IDLE;
            default: state_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= BUS_IDLE;
        else if (rst_s)
            state_q <= BUS_IDLE;
        else
            state_q <= state_d;
    end

    // The last code is kept for software, even in minimum mode where the pins stay passive.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            code_q <= STATUS_PASSIVE;
        else if (start_req && (state_q == BUS_IDLE || state_q == BUS_TAIL))
            code_q <= pwdata[CMD_CODE_LSB +: 3];
    end

    // Status is registered so the external controller sees glitch-free codes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= STATUS_PASSIVE;
        else if (rst_s || !max_mode_q)
            status_q <= STATUS_PASSIVE;
        else if (start_req && (state_q == BUS_IDLE || state_q == BUS_TAIL))
            status_q <= pwdata[CMD_CODE_LSB +: 3];
        else if ((state_q == BUS_STATE_TWO || state_q == BUS_STATE_THREE || state_q == BUS_WAIT_STATE) && ready_in)
            status_q <= STATUS_PASSIVE;
    end
    assign bus_cycle_status_out = status_q;

    always_comb
    begin
        rdata_d = '0;
        unique case (paddr)
            OFS_CTRL:
            begin
                rdata_d[CTRL_IF_BIT] = if_flag_q;
                rdata_d[CTRL_TYPE_LSB +: TYPE_W] = irq_type_q;
            end
            OFS_CMD: rdata_d[CMD_CODE_LSB +: 3] = code_q;
            OFS_STATUS:
            begin
                rdata_d[ST_STATE_LSB +: 3] = state_q;
                rdata_d[ST_MAX_BIT] = max_mode_q;
                rdata_d[ST_NMI_PEND_BIT] = nmi_pend_q;
                rdata_d[ST_WAITING_BIT] = waiting_q;
                rdata_d[ST_CORE_RST_BIT] = rst_s;
            end
            OFS_INTACK:
            begin
                rdata_d[ACK_IRQ_BIT] = irq_taken_q;
                rdata_d[ACK_NMI_BIT] = nmi_taken_q;
                rdata_d[ACK_TYPE_LSB +: TYPE_W] = taken_type_q;
            end
            OFS_VECTOR: rdata_d = vector_q;
            default: rdata_d = '0;
        endcase
    end

    // Read data is caught in the setup cycle, so a register moving during the access shows its older value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (rd_en)
            prdata <= rdata_d;
    end

    wait_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == BUS_STATE_THREE || state_q == BUS_WAIT_STATE) && !ready_in && !rst_s |=> state_q == BUS_WAIT_STATE)
        else $error("Bus left wait without acknowledge.");

    state_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == BUS_LEAD && !rst_s ##1 !rst_s [*2] |-> state_q == BUS_STATE_TWO && $past(state_q) == BUS_STATE_ONE)
        else $error("Bus states out of order.");

    min_passive_a: assert property (@(posedge pclk) disable iff (!presetn)
        !max_mode_q |=> status_q == STATUS_PASSIVE)
        else $error("Status active in minimum mode.");

    status_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == BUS_WAIT_STATE && ready_in && !start_req |=> status_q == STATUS_PASSIVE && state_q == BUS_TAIL)
        else $error("Status not passive at cycle end.");

    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_end && !if_flag_q && !rst_s && !nmi_pend_q && !nmi_edge |=> !$rose(irq_taken_q))
        else $error("Masked request was taken.");

    nmi_type_a: assert property (@(posedge pclk) disable iff (!presetn)
        instr_end && nmi_pend_q && !rst_s |=> nmi_taken_q && taken_type_q == NMI_TYPE &&
        vector_q == VECTOR_BASE + (32'(NMI_TYPE) << VEC_SHIFT))
        else $error("Pending edge not serviced as type two.");

    test_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        waiting_q && !test_s && !wait_req |=> !waiting_q)
        else $error("Wait did not end on low test.");

    flag_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(if_flag_q) |-> ##1 irq_enable_status_line == $past(if_flag_q))
        else $error("Enable status line lags flag.");

    reset_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
        rst_s |=> state_q == BUS_IDLE && status_q == STATUS_PASSIVE && !waiting_q)
        else $error("Reset did not abandon activity.");
endmodule
`default_nettype wire

// ==== cpu_ctl_far.sv ====
// Far side model: a memory device whose acknowledge is timed from the bus status code.
`timescale 1ns/10ps
`default_nettype none
module cpu_ctl_far
    import cpu_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] bus_cycle_status_out,
    input wire logic [7:0] wait_cycles,
    output logic ready_in
);
    logic [7:0] cnt_q;
    logic [1:0] hold_q;
    // The bus controller role: a cycle is seen from the code leaving passive.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 8'h00;
            hold_q <= 2'h0;
        end
        else if (bus_cycle_status_out != STATUS_PASSIVE)
        begin
            cnt_q <= cnt_q + 8'h01;
            hold_q <= (cnt_q >= wait_cycles) ? 2'h2 : 2'h0;
        end
        else
        begin
            cnt_q <= 8'h00;
            if (hold_q != 2'h0)
                hold_q <= hold_q - 2'h1;
        end
    end
    // Built from registers on pclk only, so it reaches the processor already synchronous.
    // Held a little past passive so a cycle that ended early still sees its acknowledge.
    assign ready_in = (bus_cycle_status_out != STATUS_PASSIVE) ? (cnt_q >= wait_cycles) : (hold_q != 2'h0);
endmodule
`default_nettype wire

// ==== tb_cpu_ctl.sv ====
// Testbench for the CPU control block driven over APB.
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_ctl;
    import cpu_ctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr, wait_cycles;
    logic [31:0] pwdata, prdata, r;
    logic ready_in, irq, nmi, test_n, rst_in, mode, ien_line, ack;
    logic [2:0] status;
    int err_total, compares, n;

    cpu_ctl cpu_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ready_in(ready_in), .maskable_irq_in(irq), .nmi_in(nmi), .test_n_in(test_n), .reset_in(rst_in),
        .mode_select_in(mode), .bus_cycle_status_out(status), .irq_enable_status_line(ien_line),
        .irq_ack_out(ack));
    cpu_ctl_far cpu_ctl_far_inst (.pclk(pclk), .presetn(presetn), .bus_cycle_status_out(status),
        .wait_cycles(wait_cycles), .ready_in(ready_in));

    // The source clock is high for one third of each period; only rising edges clock the block.
    always #((pclk === 1'b1) ? 8.33 : 16.67) pclk = ~pclk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Request is held until pready is sampled high; only then is it released.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task core_wait;
        int k;
        k = 0;
        r = 32'h0000_0080;
        while (r[7] !== 1'b0 && k < 20)
        begin
            apb(1'b0, OFS_STATUS, 32'h0, r);
            k++;
        end
        check({31'h0, r[7]}, 32'h0);
    endtask

    task bus_cycle(input logic [2:0] c, input logic [7:0] w);
        wait_cycles <= w;
        apb(1'b1, OFS_CMD, {24'h0, 8'h08 | {5'h00, c}}, r);
        n = 0;
        @(negedge pclk);
        while (status === STATUS_PASSIVE && n < 20)
        begin
            n++;
            @(negedge pclk);
        end
        check({29'h0, status}, {29'h0, c});
        n = 0;
        while (status !== STATUS_PASSIVE && n < 40)
        begin
            n++;
            @(negedge pclk);
        end
        check({31'h0, (n > w) && (n <= w + 3)}, 32'h1);
        @(posedge pclk);
    endtask

    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        irq = 0; nmi = 0; test_n = 0; rst_in = 0; mode = 0; wait_cycles = 8'h03;
        err_total = 0; compares = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        core_wait();
        apb(1'b0, OFS_CTRL, 32'h0, r);
        check(r, 32'h0000_0800);
        apb(1'b0, OFS_STATUS, 32'h0, r);
        check(r, 32'h0000_0010);
        apb(1'b0, 8'h20, 32'h0, r);
        check({31'h0, last_err}, 32'h1);
        check(r, 32'h0);
        for (int c = 0; c < 7; c++)
            bus_cycle(c[2:0], 8'(3 + c));
        // Flag clear: a held request must be ignored at instruction end.
        irq <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, OFS_CMD, 32'h10, r);
        apb(1'b0, OFS_INTACK, 32'h0, r);
        check(r & 32'h3, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0000_0801, r);
        @(negedge pclk);
        @(negedge pclk);
        check({31'h0, ien_line}, 32'h1);
        apb(1'b1, OFS_CMD, 32'h10, r);
        apb(1'b0, OFS_INTACK, 32'h0, r);
        check(r & 32'hFF03, 32'h0801);
        check({31'h0, ack}, 32'h1);
        apb(1'b0, OFS_VECTOR, 32'h0, r);
        check(r, 32'h20);
        apb(1'b1, OFS_INTACK, 32'h3, r);
        irq <= 1'b0;
        @(negedge pclk);
        check({31'h0, ack}, 32'h0);
        // The edge is taken with the flag clear; a level still high later is not a new edge.
        apb(1'b1, OFS_CTRL, 32'h0000_0800, r);
        nmi <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, OFS_CMD, 32'h10, r);
        apb(1'b0, OFS_INTACK, 32'h0, r);
        check(r & 32'hFF03, 32'h0202);
        apb(1'b0, OFS_VECTOR, 32'h0, r);
        check(r, 32'h8);
        apb(1'b1, OFS_INTACK, 32'h3, r);
        apb(1'b1, OFS_CMD, 32'h10, r);
        apb(1'b0, OFS_INTACK, 32'h0, r);
        check(r & 32'h3, 32'h0);
        nmi <= 1'b0;
        test_n <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, OFS_CMD, 32'h20, r);
        apb(1'b0, OFS_STATUS, 32'h0, r);
        check({31'h0, r[6]}, 32'h1);
        test_n <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0, r);
        check({31'h0, r[6]}, 32'h0);
        // A reset in the middle of a slow cycle must drop it.
        wait_cycles <= 8'd40;
        apb(1'b1, OFS_CMD, 32'h0D, r);
        repeat (3) @(posedge pclk);
        rst_in <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0, r);
        check({31'h0, r[7]}, 32'h1);
        check({29'h0, status}, {29'h0, STATUS_PASSIVE});
        rst_in <= 1'b0;
        core_wait();
        apb(1'b0, OFS_STATUS, 32'h0, r);
        check(r & 32'h7, 32'h0);
        mode <= 1'b1;
        rst_in <= 1'b1;
        repeat (5) @(posedge pclk);
        rst_in <= 1'b0;
        core_wait();
        apb(1'b0, OFS_STATUS, 32'h0, r);
        check({31'h0, r[4]}, 32'h0);
        apb(1'b1, OFS_CMD, 32'h0D, r);
        n = 0;
        repeat (10) @(negedge pclk) if (status !== STATUS_PASSIVE) n++;
        check(n, 0);
        test_done();
    end

    // The whole sequence needs well under 2000 cycles.
    initial
    begin
        #(25 * 20000);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
